/* File: hdl/fpwp_pkg.sv */
// shared constants and types for the flash page write port
package fpwp_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int WSEL_W = 2;
    localparam int STAT_W = 2;
    localparam int BLK_W = 4;
    localparam int PAGE_W = 9;
    localparam int BLK_LSB = 7;
    localparam int PAGE_LSB = 11;
    localparam int WORDS_PER_BLK_W = 7;
    localparam logic [3:0] BLOCKS_PER_PAGE = 4'h9;
    localparam logic [2:0] BLK_READ_CYC = 3'h5;
    localparam logic [2:0] SWITCH_CYC = 3'h4;
    localparam logic [2:0] SWITCH_CYC_PIPE = 3'h5;
    localparam logic [6:0] COPY_MIN_CYC = 7'h37;
    localparam logic [STAT_W-1:0] ST_OK = 2'h0;
    localparam logic [STAT_W-1:0] ST_PROT = 2'h1;
    localparam logic [STAT_W-1:0] ST_LOSS = 2'h3;
    localparam logic [STAT_W-1:0] ST_RESET = 2'h0;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR = 8'h14;
    localparam logic [7:0] REG_IRQ_EN = 8'h18;
    localparam logic [7:0] REG_PROT = 8'h1c;
    localparam logic [7:0] REG_CTRL = 8'h20;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    typedef enum logic [1:0] {
        FPWP_IDLE = 2'b00,
        FPWP_COPY = 2'b01,
        FPWP_SWITCH = 2'b10,
        FPWP_RELOAD = 2'b11
    } fpwp_state_t;
endpackage

/* File: hdl/fpwp_if.sv */
// link between the user logic and the flash block write port
interface fpwp_if;
    import fpwp_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic [WSEL_W-1:0] word_width_sel;
    logic pipe;
    logic busy;
    logic [STAT_W-1:0] status;
    modport flash_block (input wr_en, input addr, input wr_data, input word_width_sel, input pipe,
                         output busy, output status);
    modport user (output wr_en, output addr, output wr_data, output word_width_sel, output pipe,
                  input busy, input status);
endinterface

/* File: hdl/fpwp_flash_block.sv */
// flash block write side: page buffer, block buffer, busy and status
//
// Summary of operation
// - operations taken only while busy is low
// - busy driven from a sys_clk flip-flop
// - user starts write with enable, address, data
// - missing page: busy at least 55 cycles
// - nine blocks, 5 read plus 1 write
// - write in buffered block: no busy
// - other block: busy four, five with pipe
// - status 00 good; error skips write
// - status held until next operation
// - one word per write, width selected
// - any address order, no full-page demand
// - user tracks buffer and commit time
// - overwrite-protected page refused, status 01
// - page-loss protection miss refused, status 11
module fpwp_flash_block
    import fpwp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // link
    fpwp_if.flash_block lnk,
    // protection controls
    input wire logic [(1<<fpwp_pkg::PAGE_W)-1:0] page_prot,
    input wire logic page_loss_prot,
    // page buffer read-back
    input wire logic [fpwp_pkg::ADDR_W-fpwp_pkg::PAGE_W-1:0] rd_idx,
    output logic [fpwp_pkg::DATA_W-1:0] rd_data,
    output logic page_valid
);
    import fpwp_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    localparam int PB_WORDS = 1 << (ADDR_W - PAGE_W);
    logic [DATA_W-1:0] pbuf_q [PB_WORDS];
    logic [PAGE_W-1:0] page_q;
    logic page_valid_q;
    logic [BLK_W-1:0] blk_q;
    fpwp_state_t state_q;
    logic [3:0] blk_cnt_q;
    logic [2:0] cyc_q;
    logic busy_q;
    logic [STAT_W-1:0] status_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic [WSEL_W-1:0] wsel_q;
    logic [DATA_W-1:0] rd_data_q;

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                                input logic [DATA_W-1:0] new_w,
                                                input logic [WSEL_W-1:0] sel);
        logic [DATA_W-1:0] mask;
        mask = (sel == 2'h0) ? 32'h000000ff : (sel == 2'h1) ? 32'h0000ffff : 32'hffffffff;
        return (old_w & ~mask) | (new_w & mask);
    endfunction

    // address fields, decoded for the live request and for the held one
    function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
        // the page field is narrower than the protection index, so pad it on top
        return {{(PAGE_W-(ADDR_W-PAGE_LSB)){1'b0}}, a[ADDR_W-1:PAGE_LSB]};
    endfunction

    function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
        return a[PAGE_LSB-1:BLK_LSB];
    endfunction

    // only the low block bits reach the index, so blocks four apart share words here
    function automatic logic [ADDR_W-PAGE_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-PAGE_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    wire [PAGE_W-1:0] req_page = page_of(lnk.addr);
    wire [BLK_W-1:0] req_blk = blk_of(lnk.addr);
    wire [ADDR_W-PAGE_W-1:0] req_idx = idx_of(lnk.addr);
    wire take = lnk.wr_en && !busy_q && (state_q == FPWP_IDLE);
    wire same_page = page_valid_q && (req_page == page_q);
    wire err_prot = page_prot[req_page];
    wire err_loss = !same_page && page_loss_prot;
    wire err = err_prot || err_loss;
    wire [STAT_W-1:0] err_code = err_prot ? ST_PROT : ST_LOSS;
    wire copy_step_done = (cyc_q == BLK_READ_CYC);
    wire [2:0] switch_len = lnk.pipe ? SWITCH_CYC_PIPE : SWITCH_CYC;
    wire [ADDR_W-PAGE_W-1:0] wr_idx = idx_of(addr_q);

    ////////////////////////////////////////////////////////////////////////////
    // buffer write port: erase fill at copy start, a direct in-page write,
    // or the reload that lands the request held through a copy
    wire pb_init = (state_q == FPWP_COPY) && (blk_cnt_q == 4'h0) && (cyc_q == 3'h1);
    wire pb_direct = take && !err && same_page;
    wire pb_reload = (state_q == FPWP_RELOAD);
    wire pb_we = pb_direct || pb_reload;
    wire [ADDR_W-PAGE_W-1:0] pb_widx = pb_direct ? req_idx : wr_idx;
    wire [DATA_W-1:0] pb_wdata = pb_direct ? merge(pbuf_q[req_idx], lnk.wr_data, lnk.word_width_sel)
                                           : merge(pbuf_q[wr_idx], data_q, wsel_q);

    assign rd_data = rd_data_q;
    assign page_valid = page_valid_q;
    assign lnk.busy = busy_q;
    assign lnk.status = status_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= FPWP_IDLE;
            busy_q <= 1'b0;
            status_q <= ST_RESET;
            page_valid_q <= 1'b0;
            page_q <= '0;
            blk_q <= '0;
            blk_cnt_q <= 4'h0;
            cyc_q <= 3'h0;
            addr_q <= '0;
            data_q <= '0;
            wsel_q <= '0;
        end else begin
            unique case (state_q)
                FPWP_IDLE: begin
                    if (take) begin
                        addr_q <= lnk.addr;
                        data_q <= lnk.wr_data;
                        wsel_q <= lnk.word_width_sel;
                        cyc_q <= 3'h1;
                        if (err) begin
                            status_q <= err_code;
                        end else begin
                            status_q <= ST_OK;
                            if (!same_page) begin
                                state_q <= FPWP_COPY;
                                busy_q <= 1'b1;
                                blk_cnt_q <= 4'h0;
                                cyc_q <= 3'h0;
                                page_q <= req_page;
                                blk_q <= req_blk;
                            end else if (req_blk != blk_q) begin
                                state_q <= FPWP_SWITCH;
                                busy_q <= 1'b1;
                                cyc_q <= switch_len;
                                blk_q <= req_blk;
                            end
                        end
                    end
                end
                // five read cycles then one write per block
                FPWP_COPY: begin
                    if (copy_step_done) begin
                        cyc_q <= 3'h0;
                        if (blk_cnt_q == BLOCKS_PER_PAGE - 4'h1) begin
                            state_q <= FPWP_RELOAD;
                            page_valid_q <= 1'b1;
                        end else begin
                            blk_cnt_q <= blk_cnt_q + 4'h1;
                        end
                    end else begin
                        cyc_q <= cyc_q + 3'h1;
                    end
                end
                FPWP_SWITCH: begin
                    if (cyc_q == 3'h1) begin
                        state_q <= FPWP_IDLE;
                        busy_q <= 1'b0;
                    end else begin
                        cyc_q <= cyc_q - 3'h1;
                    end
                end
                FPWP_RELOAD: begin
                    state_q <= FPWP_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // no array model: a copied page reads as erased, since only the write path is built here
    // each word is its own flop row; a one-cycle fill keeps the copy model short
    genvar gi;
    generate
        for (gi = 0; gi < PB_WORDS; gi++) begin : g_word
            always_ff @(posedge sys_clk) begin
                if (pb_init) begin
                    pbuf_q[gi] <= 32'hffffffff;
                end else if (pb_we && (pb_widx == (ADDR_W-PAGE_W)'(gi))) begin
                    pbuf_q[gi] <= pb_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read-back registered so the port comes from a flop, one cycle behind rd_idx
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_q <= 32'h0;
        end else begin
            rd_data_q <= pbuf_q[rd_idx];
        end
    end
endmodule

/* File: hdl/fpwp_user.sv */
// user-logic end: register port, request holding, interrupts
module fpwp_user
    import fpwp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // software port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // link
    fpwp_if.user lnk
);
    import fpwp_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic pend_q;
    logic inflight_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic [WSEL_W-1:0] wsel_q;
    logic pipe_q;
    logic [IRQ_W-1:0] ist_q;
    logic [IRQ_W-1:0] ien_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic [ADDR_W-PAGE_LSB-1:0] op_page_q;
    logic [ADDR_W-PAGE_LSB-1:0] held_page_q;
    logic held_valid_q;

    wire wr_cmd = reg_wr && (reg_addr == REG_CMD) && reg_wdata[0];
    wire taken = pend_q && !lnk.busy;
    wire done = inflight_q && !lnk.busy && !pend_q;
    wire [IRQ_W-1:0] ev = {done && (lnk.status != ST_OK), done};
    wire [IRQ_W-1:0] clr = (reg_wr && reg_addr == REG_IRQ_CLR) ? reg_wdata[IRQ_W-1:0] : '0;
    wire [31:0] rd_mux =
        (reg_addr == REG_ADDR) ? {{(32-ADDR_W){1'b0}}, addr_q} :
        (reg_addr == REG_DATA) ? data_q :
        (reg_addr == REG_STAT) ? {21'h0, held_page_q, held_valid_q, pend_q | inflight_q, lnk.status} :
        (reg_addr == REG_IRQ_STAT) ? {30'h0, ist_q} :
        (reg_addr == REG_IRQ_EN) ? {30'h0, ien_q} :
        (reg_addr == REG_CTRL) ? {29'h0, pipe_q, wsel_q} : 32'h0;

    assign lnk.wr_en = pend_q;
    assign lnk.addr = addr_q;
    assign lnk.wr_data = data_q;
    assign lnk.word_width_sel = wsel_q;
    assign lnk.pipe = pipe_q;
    assign reg_rdata = rdata_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_q <= 1'b0;
            inflight_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            wsel_q <= '0;
            pipe_q <= 1'b0;
            ist_q <= '0;
            ien_q <= '0;
            rdata_q <= 32'h0;
            irq_q <= 1'b0;
            op_page_q <= '0;
            held_page_q <= '0;
            held_valid_q <= 1'b0;
        end else begin
            // address and data frozen while a request waits
            if (reg_wr && reg_addr == REG_ADDR && !pend_q) addr_q <= reg_wdata[ADDR_W-1:0];
            if (reg_wr && reg_addr == REG_DATA && !pend_q) data_q <= reg_wdata;
            if (reg_wr && reg_addr == REG_CTRL && !pend_q) begin
                wsel_q <= reg_wdata[WSEL_W-1:0];
                pipe_q <= reg_wdata[2];
            end
            if (reg_wr && reg_addr == REG_IRQ_EN) ien_q <= reg_wdata[IRQ_W-1:0];
            if (taken) begin
                pend_q <= 1'b0;
                inflight_q <= 1'b1;
                op_page_q <= addr_q[ADDR_W-1:PAGE_LSB];
            end else if (wr_cmd && !inflight_q) begin
                pend_q <= 1'b1;
            end
            if (done) inflight_q <= 1'b0;
            // track which page the buffer holds
            if (done && lnk.status == ST_OK) begin
                held_page_q <= op_page_q;
                held_valid_q <= 1'b1;
            end
            // set wins over clear
            ist_q <= (ist_q & ~clr) | ev;
            irq_q <= |(((ist_q & ~clr) | ev) & ien_q);
            rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end
endmodule

/* File: bench/fpwp_assertions.sv */
// link checker between the user logic and the flash block
module fpwp_assertions
    import fpwp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // link
    input wire logic wr_en,
    input wire logic [fpwp_pkg::ADDR_W-1:0] addr,
    input wire logic [fpwp_pkg::DATA_W-1:0] wr_data,
    input wire logic [fpwp_pkg::WSEL_W-1:0] word_width_sel,
    input wire logic pipe,
    input wire logic busy,
    input wire logic [fpwp_pkg::STAT_W-1:0] status
);
    import fpwp_pkg::*;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic pipe_q;
    wire take = wr_en && !busy;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // run length of busy, and the pipe choice held from the accept
    assign cnt_d = busy ? cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge sys_clk) begin
        cnt_q <= rst ? 8'h00 : cnt_d;
        pipe_q <= rst ? 1'b0 : (take ? pipe : pipe_q);
    end
    ////////////////////////////////////////////////////////////////
    a_idle_stays: assert property (!wr_en && !busy |=> !busy) else $error("busy rose without request");
    a_take_only: assert property ($rose(busy) |-> $past(wr_en) && !$past(busy))
        else $error("busy rose without accept");
    // a stall shorter than four cycles is never legal
    a_busy_min: assert property ($rose(busy) |-> busy [*4]) else $error("busy too short");
    // reset in mid-stall cuts the run short, so skip that edge
    a_busy_len: assert property ($fell(busy) && !$past(rst) |-> (cnt_q == 8'h04 && !pipe_q)
        || (cnt_q == 8'h05 && pipe_q) || cnt_q >= 8'h37) else $error("busy length wrong");
    a_busy_bound: assert property (busy |-> cnt_q < 8'h40) else $error("busy too long");
    a_refused_idle: assert property (take ##1 status != ST_OK |-> !busy) else $error("refused op stalled");
    a_status_code: assert property (status != 2'h2) else $error("undefined status");
    a_status_sticky: assert property (!take |=> $stable(status)) else $error("status moved");
    a_request_held: assert property (wr_en && busy |=> wr_en && $stable(addr) && $stable(wr_data)
        && $stable(word_width_sel)) else $error("request dropped");
    c_copy: cover property ($fell(busy) && cnt_q == 8'h37);
    c_switch: cover property ($fell(busy) && cnt_q == 8'h04);
    c_prot: cover property (status == ST_PROT);
    c_loss: cover property (status == ST_LOSS);
endmodule

/* File: bench/testbench.sv */
// testbench: user end and flash block joined, driven over the register port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fpwp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq;
    logic [(1<<PAGE_W)-1:0] page_prot = '0;
    logic page_loss_prot = 1'b0;
    logic [8:0] rd_idx = 9'h000;
    logic page_valid;
    logic [31:0] rd_data;
    logic [31:0] s;
    int n_mismatch = 0;
    int compares = 0;
    fpwp_if lnk ();
    fpwp_user fpwp_user_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .lnk);
    fpwp_flash_block fpwp_flash_block_inst (.sys_clk, .rst, .lnk, .page_prot, .page_loss_prot, .rd_idx,
        .rd_data, .page_valid);
    fpwp_assertions fpwp_assertions_inst (.sys_clk, .rst, .wr_en(lnk.wr_en), .addr(lnk.addr),
        .wr_data(lnk.wr_data), .word_width_sel(lnk.word_width_sel), .pipe(lnk.pipe), .busy(lnk.busy),
        .status(lnk.status));
    initial forever #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // one write: busy cycles counted on the link over a window longer than a copy
    task automatic op(input logic [17:0] a, input logic [2:0] ctrl, input int nb, input logic [1:0] st);
        int n;
        n = 0;
        wr(REG_CTRL, {29'h0, ctrl});
        wr(REG_ADDR, {14'h0, a});
        wr(REG_DATA, {14'h1a5, a});
        wr(REG_CMD, 32'h1);
        repeat (70) begin
            @(posedge sys_clk);
            if (lnk.busy === 1'b1) n++;
        end
        check(n, nb, "busy cycles");
        rd(REG_STAT, s);
        check(s[2:0], {1'b0, st}, "status");
        check(lnk.word_width_sel, ctrl[1:0], "width");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_writes();
        op(18'h00800, 3'h2, 55, ST_OK);
        check(page_valid, 1'b1, "page valid");
        rd(REG_STAT, s);
        check(s[10:3], 8'h03, "held page");
        // erased word, then byte, half and full lanes merged in turn
        for (int w = 0; w < 4; w++) begin
            op(18'h00804, 3'(w), 0, ST_OK);
            @(posedge sys_clk);
            rd_idx <= 9'h004;
            repeat (2) @(posedge sys_clk);
            check(rd_data, (w == 0) ? 32'hffffff04 : (w == 1) ? 32'hffff0804 : 32'h06940804, "lanes");
        end
        op(18'h00900, 3'h2, 4, ST_OK);
        op(18'h00980, 3'h6, 5, ST_OK);
        op(18'h00904, 3'h2, 4, ST_OK);
        $display("test writes done");
    endtask
    task automatic t_errors();
        @(posedge sys_clk);
        page_prot[3] <= 1'b1;
        page_prot[1] <= 1'b1;
        op(18'h01800, 3'h2, 0, ST_PROT);
        // a refused write into the buffered page must leave its word erased
        op(18'h00905, 3'h2, 0, ST_PROT);
        @(posedge sys_clk);
        rd_idx <= 9'h105;
        repeat (2) @(posedge sys_clk);
        check(rd_data, 32'hffffffff, "refused word");
        page_prot <= '0;
        page_loss_prot <= 1'b1;
        op(18'h02800, 3'h2, 0, ST_LOSS);
        repeat (20) @(posedge sys_clk);
        rd(REG_STAT, s);
        check(s[1:0], ST_LOSS, "sticky status");
        check(s[10:3], 8'h03, "held page kept");
        page_loss_prot <= 1'b0;
        $display("test errors done");
    endtask
    task automatic t_irq();
        wr(REG_IRQ_CLR, 32'h3);
        wr(REG_IRQ_EN, 32'h3);
        op(18'h00904, 3'h2, 0, ST_OK);
        check(irq, 1'b1, "irq raised");
        rd(REG_IRQ_STAT, s);
        check(s[1:0], 2'h1, "irq status");
        wr(REG_IRQ_CLR, 32'h1);
        @(posedge sys_clk);
        check(irq, 1'b0, "irq cleared");
        wr(REG_IRQ_EN, 32'h0);
        op(18'h00904, 3'h2, 0, ST_OK);
        check(irq, 1'b0, "irq masked");
        $display("test irq done");
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_writes();
        t_errors();
        t_irq();
        finish_test();
    end
    // thirteen writes of under a hundred cycles each
    initial begin
        repeat (4000) @(posedge sys_clk);
        n_mismatch++;
        $display("wrong value at %0t: run hung", $time);
        finish_test();
    end
endmodule
